// ### pkg/cirp_pkg.sv
// Package of constants for the chip identification, reset cause and protect register bank
// Functional notes
// (R1) Registers decode from base 0xfff00000; offsets 0x0c to 0x14 are reserved, no function.
// (R2) Identification word holds a five-bit version, zero upward, at most 31.
// (R3) Program memory size codes: 0000 none, 0011 32K, 0101 64K, 0111 128K, 1001 256K.
// (R4) Nonvolatile data memory size field reads 0000, meaning none present.
// (R5) Volatile memory size one-hot: 0000 none, 0001 1K, 0010 2K, 0100 4K, 1000 8K.
// (R6) Architecture field is an eight-bit hardwired pair of BCD digits.
// (R7) Program memory type: 001 mask ROM, 010 parallel flash, 011 serial flash.
// (R8) Bit 31 extension flag reads 0 without extension, 1 with one.
// (R9) Extension word at offset 0x04 is read-only and reserved, no defined content.
// (R10) Reset cause reads 0x6c after pin reset, 0x53 after watchdog reset.
// (R11) Protect register write takes effect only when upper key equals 0x27a8.
// (R12) Key field of the protect register always reads back as zero.
// (R13) Protect bit 5: 0 normal interrupt mode, 1 protect mode; resets to 0.
// (R14) Reset cause in low eight bits, loaded at every reset, upper bits zero.
// (R15) Writes to read-only and reserved offsets do nothing; reserved reads return zero.
// (R16) Watchdog overflow since restart or reset makes the reset cause read watchdog.
package cirp_pkg;
  // ==========================================================
  // Address map
  localparam logic [31:0] CIRP_BASE = 32'hfff00000;
  localparam logic [7:0] CIRP_OFS_ID = 8'h00;
  localparam logic [7:0] CIRP_OFS_EXT = 8'h04;
  localparam logic [7:0] CIRP_OFS_RST = 8'h08;
  localparam logic [7:0] CIRP_OFS_PMR = 8'h18;
  localparam int CIRP_DEC_BITS = 8;
  // ==========================================================
  // Identification fields
  localparam int CIRP_EXT_POS = 31;
  localparam int CIRP_TYP_POS = 28;
  localparam int CIRP_ARCHITECTURE_CODE_POS = 20;
  localparam int CIRP_VSIZ_POS = 16;
  localparam int CIRP_NVD_POS = 12;
  localparam int CIRP_NVP_POS = 8;
  localparam int CIRP_FIX_POS = 5;
  localparam logic [2:0] CIRP_FIX_BITS = 3'h2;
  localparam logic [3:0] CIRP_NVP_NONE = 4'h0;
  localparam logic [3:0] CIRP_NVP_32K = 4'h3;
  localparam logic [3:0] CIRP_NVP_64K = 4'h5;
  localparam logic [3:0] CIRP_NVP_128K = 4'h7;
  localparam logic [3:0] CIRP_NVP_256K = 4'h9;
  localparam logic [3:0] CIRP_NVD_NONE = 4'h0;
  localparam logic [3:0] CIRP_VD_NONE = 4'h0;
  localparam logic [3:0] CIRP_VD_1K = 4'h1;
  localparam logic [3:0] CIRP_VD_2K = 4'h2;
  localparam logic [3:0] CIRP_VD_4K = 4'h4;
  localparam logic [3:0] CIRP_VD_8K = 4'h8;
  localparam logic [2:0] CIRP_TYP_MASK = 3'h1;
  localparam logic [2:0] CIRP_TYP_PFLASH = 3'h2;
  localparam logic [2:0] CIRP_TYP_SFLASH = 3'h3;
  localparam logic [4:0] CIRP_VER_MAX = 5'h1f;
  // ==========================================================
  // Reset cause and protect register
  localparam logic [7:0] CIRP_CAUSE_PIN = 8'h6c;
  localparam logic [7:0] CIRP_CAUSE_WDOG = 8'h53;
  localparam logic [15:0] CIRP_KEY = 16'h27a8;
  localparam int CIRP_KEY_POS = 16;
  localparam int CIRP_PROT_POS = 5;
  localparam logic CIRP_PROT_RST = 1'b0;
  typedef enum logic {CIRP_IDLE, CIRP_ACKED} cirp_bus_t;
endpackage

// ### rtl/cirp_rdreg.sv
// Registered read data holder for the register bank
`timescale 1ns/100ps
module cirp_rdreg (
  input wire logic clk, // System clock
  input wire logic resetn, // Synchronous reset, low active
  input wire logic ce, // Clock enable
  input wire logic load, // Capture strobe
  input wire logic [31:0] din, // Data to capture
  output logic [31:0] dout // Held data
);
  // Captured on the accepted cycle so read data comes from a flop
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dout <= 32'h00000000;
    end else if (ce && load) begin
      dout <= din;
    end
  end
endmodule

// ### rtl/cirp_regs.sv
// Chip identification, reset cause and protect mode register bank on classic Wishbone
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
module cirp_regs
  import cirp_pkg::*;
#(
  parameter logic [4:0] VERSION = 5'h00, // Silicon revision
  parameter logic [7:0] ARCHITECTURE_CODE_CODE = 8'h11, // Arbitrary value, replace per product
  parameter logic [2:0] PROG_TYPE = CIRP_TYP_MASK, // Program memory type
  parameter logic [3:0] PROG_SIZE = CIRP_NVP_NONE, // Program memory size code
  parameter logic [3:0] VOL_SIZE = CIRP_VD_2K, // Volatile memory size code
  parameter logic EXT_PRESENT = 1'b0, // Extension word defined
  parameter logic [31:0] EXT_WORD = 32'h00000000 // Arbitrary value, extension content
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Synchronous reset, low active
  input wire logic ce, // Freezes all state when low, but synchronous reset still acts
  input wire logic watchdog_overflow_flag, // Watchdog overflow since restart
  input wire logic [31:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [3:0] wb_sel_i, // Byte lane selects
  input wire logic wb_we_i, // Write enable
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic interrupt_ctrl_protect // Interrupt controller protect mode
);
  // ==========================================================
  // Bus decode
  cirp_bus_t state;
  cirp_bus_t next_state;
  logic [7:0] reset_cause;
  logic wdog_seen;
  logic in_reset;
  logic [31:0] chip_identification;
  logic [31:0] rd_mux;
  logic [4:0] ver_field;
  wire base_hit = (wb_adr_i[31:CIRP_DEC_BITS] == CIRP_BASE[31:CIRP_DEC_BITS]); // [R1]
  wire [7:0] ofs = wb_adr_i[7:0];
  wire req = wb_cyc_i && wb_stb_i && (state == CIRP_IDLE);
  wire take = req && ce;
  wire hit_id = base_hit && (ofs == CIRP_OFS_ID);
  wire hit_ext = base_hit && (ofs == CIRP_OFS_EXT);
  wire hit_rst = base_hit && (ofs == CIRP_OFS_RST);
  wire hit_pmr = base_hit && (ofs == CIRP_OFS_PMR);
  wire key_ok = (wb_dat_i[31:CIRP_KEY_POS] == CIRP_KEY); // [R11]
  // Key lives in the two upper lanes, bit 5 in lane 0; all three must be selected
  wire lanes_ok = wb_sel_i[3] && wb_sel_i[2] && wb_sel_i[0];
  wire pmr_wr = take && wb_we_i && hit_pmr && key_ok && lanes_ok; // [R11]

  // Version saturates at its five-bit ceiling
  assign ver_field = (VERSION > CIRP_VER_MAX) ? CIRP_VER_MAX : VERSION; // [R2]
  // Identification word is hardwired from the parameters
  assign chip_identification = {EXT_PRESENT, PROG_TYPE, ARCHITECTURE_CODE_CODE, VOL_SIZE, // [R5] [R6] [R7] [R8]
                                CIRP_NVD_NONE, PROG_SIZE, // [R3] [R4]
                                CIRP_FIX_BITS, ver_field}; // [R2]
  // Read select; reserved and foreign offsets give zero
  assign rd_mux = hit_id ? chip_identification :
                  hit_ext ? (EXT_PRESENT ? EXT_WORD : 32'h00000000) : // [R9]
                  hit_rst ? {24'h000000, reset_cause} : // [R14]
                  hit_pmr ? {26'h0000000, interrupt_ctrl_protect, 5'h00} : // [R12]
                  32'h00000000; // [R15]
  assign next_state = (state == CIRP_ACKED) ? CIRP_IDLE : (req ? CIRP_ACKED : CIRP_IDLE);
  assign wb_ack_o = (state == CIRP_ACKED);

  // ==========================================================
  // Handshake: one wait cycle, ack for one cycle, then idle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= CIRP_IDLE;
    end else if (ce) begin
      case (state)
        CIRP_IDLE: state <= next_state;
        CIRP_ACKED: state <= next_state;
        default: state <= CIRP_IDLE;
      endcase
    end
  end

  cirp_rdreg u_rd (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .load(take),
    .din(rd_mux),
    .dout(wb_dat_o)
  );

  // ==========================================================
  // Protect mode bit; only a keyed write changes it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      interrupt_ctrl_protect <= CIRP_PROT_RST; // [R13]
    end else if (ce && pmr_wr) begin
      interrupt_ctrl_protect <= wb_dat_i[CIRP_PROT_POS]; // [R13]
    end
  end

  // ==========================================================
  // Marks the second and later edges of a held reset
  always_ff @(posedge clk) begin
    in_reset <= !resetn;
  end

  // Reset cause: watchdog overflow seen while running is remembered so that
  // the next reset loads the watchdog code; otherwise the reset came from the pin.
  // A watchdog cause is held across a reset that lasts many cycles.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      if (in_reset && (reset_cause == CIRP_CAUSE_WDOG)) begin
        reset_cause <= reset_cause; // [R10]
      end else if (wdog_seen) begin
        reset_cause <= CIRP_CAUSE_WDOG; // [R10] [R14] [R16]
      end else begin
        reset_cause <= CIRP_CAUSE_PIN; // [R10] [R14]
      end
    end
  end

  // Sticky overflow marker, cleared only after the first reset edge has used it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      if (in_reset) begin
        wdog_seen <= 1'b0;
      end
    end else if (ce && watchdog_overflow_flag) begin
      wdog_seen <= 1'b1; // [R16]
    end
  end

  // ==========================================================
  // Checks
  logic past_valid;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      past_valid <= 1'b0;
    end else begin
      past_valid <= 1'b1;
    end
  end

  sequence s_keyed_write;
    pmr_wr;
  endsequence

  property p_base_decode;
    @(posedge clk) disable iff (!resetn)
      (take && !base_hit) |=> (wb_dat_o == 32'h00000000);
  endproperty
  a_base_decode: assert property (p_base_decode) else $error("foreign address read nonzero"); // [R1]

  property p_reserved_zero;
    @(posedge clk) disable iff (!resetn)
      (take && base_hit && (ofs == 8'h0c || ofs == 8'h10 || ofs == 8'h14))
        |=> (wb_dat_o == 32'h00000000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved offset nonzero"); // [R15]

  property p_id_fields;
    @(posedge clk) disable iff (!resetn)
      (take && hit_id) |=> (wb_dat_o[15:12] == CIRP_NVD_NONE && wb_dat_o[7:5] == CIRP_FIX_BITS
                            && wb_dat_o[31] == EXT_PRESENT);
  endproperty
  a_id_fields: assert property (p_id_fields) else $error("id word fields wrong"); // [R4] [R8]

  property p_key_reads_zero;
    @(posedge clk) disable iff (!resetn)
      (take && hit_pmr) |=> (wb_dat_o[31:6] == 26'h0000000 && wb_dat_o[4:0] == 5'h00);
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("key bits read nonzero"); // [R12]

  property p_keyed_write;
    @(posedge clk) disable iff (!resetn)
      s_keyed_write |=> (interrupt_ctrl_protect == $past(wb_dat_i[5]));
  endproperty
  a_keyed_write: assert property (p_keyed_write) else $error("keyed write not applied"); // [R11]

  property p_bad_key;
    @(posedge clk) disable iff (!resetn)
      (take && wb_we_i && hit_pmr && !key_ok) |=> $stable(interrupt_ctrl_protect);
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("unkeyed write changed protect"); // [R11]

  property p_cause_code;
    @(posedge clk) disable iff (!resetn)
      past_valid |-> (reset_cause == CIRP_CAUSE_PIN || reset_cause == CIRP_CAUSE_WDOG);
  endproperty
  a_cause_code: assert property (p_cause_code) else $error("reset cause code invalid"); // [R10]

  property p_cause_read;
    @(posedge clk) disable iff (!resetn)
      (take && hit_rst) |=> (wb_dat_o == {24'h000000, reset_cause});
  endproperty
  a_cause_read: assert property (p_cause_read) else $error("reset cause read wrong"); // [R14]

  property p_ack_one;
    @(posedge clk) disable iff (!resetn)
      (ce && wb_ack_o) |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle"); // [R15]
endmodule

// ### sim/test_cirp_regs.sv
// Self-checking bench for the identification, reset cause and protect register bank
`timescale 1ns/100ps
module test_cirp_regs;
  import cirp_pkg::*;
  // ==========================================================
  // Expected identification word, built field by field
  localparam logic [31:0] ID_EXP = {1'b0, CIRP_TYP_SFLASH, 8'h11, CIRP_VD_8K, CIRP_NVD_NONE,
    CIRP_NVP_256K, CIRP_FIX_BITS, CIRP_VER_MAX};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic watchdog_overflow_flag = 1'b0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic interrupt_ctrl_protect;
  int num_errors = 0;
  int checks_done = 0;
  int m_prot = 0;
  int m_cause = int'(CIRP_CAUSE_PIN);
  // ==========================================================
  // Clock and design
  always #2.5 clk = ~clk;
  cirp_regs #(
    .VERSION(CIRP_VER_MAX), // Top of the version range
    .ARCHITECTURE_CODE_CODE(8'h11), // Arbitrary value
    .PROG_TYPE(CIRP_TYP_SFLASH),
    .PROG_SIZE(CIRP_NVP_256K),
    .VOL_SIZE(CIRP_VD_8K)
  ) i_dut (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .watchdog_overflow_flag(watchdog_overflow_flag),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .interrupt_ctrl_protect(interrupt_ctrl_protect)
  );
  // ==========================================================
  // Reference model and helpers
  function automatic logic [31:0] model_rd(input logic [31:0] a);
    if (a[31:8] != CIRP_BASE[31:8]) return 32'h0;
    case (a[7:0])
      CIRP_OFS_ID: return ID_EXP;
      CIRP_OFS_RST: return 32'(m_cause);
      CIRP_OFS_PMR: return 32'(m_prot) << CIRP_PROT_POS;
      default: return 32'h0;
    endcase
  endfunction
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", name, e, g);
      num_errors++;
    end
  endtask
  // One classic cycle; waits for ack under a bound, then idles a cycle
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= s;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    r = wb_dat_o;
    if (n >= 50) begin
      $display("MISMATCH wb_ack_o expected 1 seen %b", wb_ack_o);
      num_errors++;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk);
  endtask
  // Write, track the model, then check the pin and a read back
  task automatic wr_chk(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    bus(a, 1'b1, d, s, r);
    if (a == CIRP_BASE + 32'(CIRP_OFS_PMR) && d[31:16] == CIRP_KEY && s[3] && s[2] && s[0])
      m_prot = int'(d[CIRP_PROT_POS]);
    chk("protect_pin", 32'(m_prot), {31'h0, interrupt_ctrl_protect});
    bus(a, 1'b0, 32'h0, 4'hf, r);
    chk("readback", model_rd(a), r);
  endtask
  // Optional overflow pulse ahead of a 16-cycle reset
  task automatic do_reset(input logic wd);
    logic [31:0] r;
    watchdog_overflow_flag <= wd;
    @(posedge clk);
    watchdog_overflow_flag <= 1'b0;
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    m_cause = wd ? int'(CIRP_CAUSE_WDOG) : int'(CIRP_CAUSE_PIN);
    m_prot = 0;
    @(posedge clk);
    chk("protect_pin", 32'h0, {31'h0, interrupt_ctrl_protect});
    bus(CIRP_BASE + 32'(CIRP_OFS_RST), 1'b0, 32'h0, 4'hf, r);
    chk("reset_cause", model_rd(CIRP_BASE + 32'(CIRP_OFS_RST)), r);
  endtask
  task automatic complete_run;
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] r;
    void'($urandom(32'hb3a7));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // Every offset, reserved ones included, plus a foreign base
    for (int i = 0; i < 9; i++) begin
      a = (i == 8) ? 32'hfff10018 : CIRP_BASE + 32'(i * 4);
      bus(a, 1'b0, 32'h0, 4'hf, r);
      chk("read", model_rd(a), r);
    end
    wr_chk(CIRP_BASE + 32'h18, {CIRP_KEY, 16'h0020}, 4'hf);
    wr_chk(CIRP_BASE + 32'h18, {CIRP_KEY ^ 16'h0001, 16'h0000}, 4'hf);
    wr_chk(CIRP_BASE + 32'h18, {CIRP_KEY, 16'h0000}, 4'hf);
    // Random writes to the base offsets, each keyed on a coin flip
    for (int i = 0; i < 24; i++) begin
      a = CIRP_BASE + 32'(($urandom % 8) * 4);
      d = $urandom;
      if ($urandom % 2) d[31:16] = CIRP_KEY;
      wr_chk(a, d, 4'($urandom));
    end
    wr_chk(CIRP_BASE + 32'h18, {CIRP_KEY, 16'h0020}, 4'hf);
    // Clock enable low: a keyed clear must neither be acked nor applied
    ce <= 1'b0;
    wb_adr_i <= CIRP_BASE + 32'(CIRP_OFS_PMR);
    wb_dat_i <= {CIRP_KEY, 16'h0000};
    wb_sel_i <= 4'hf;
    wb_we_i <= 1'b1;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    repeat (4) @(posedge clk);
    chk("frozen_ack", 32'h0, {31'h0, wb_ack_o});
    chk("frozen_protect", 32'h1, {31'h0, interrupt_ctrl_protect});
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    ce <= 1'b1;
    @(posedge clk);
    do_reset(1'b1);
    do_reset(1'b0);
    complete_run;
  end
  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge clk);
    $display("MISMATCH run_length expected done seen hung");
    num_errors++;
    complete_run;
  end
endmodule
